// *** logic/cvc_top.sv ***
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
module cvc_top (
	input  wire logic              ref_clk,
	input  wire logic              rst_n,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic                   pready,
	output logic [31:0]            prdata,
	output logic                   pslverr,
	input  wire logic              raw_first_compare,
	input  wire logic              raw_second_compare,
	input  wire logic              peripheral_irq_enable,
	input  wire logic              global_irq_enable,
	input  wire logic              first_pin_direction,
	input  wire logic              second_pin_direction,
	input  wire logic              ladder_pin_direction,
	input  wire logic              output_routing_enable,
	input  wire logic [7:1]        port_pin_level,
	input  wire logic [7:1]        pin_is_analog,
	output cvc_pkg::cvc_cmp_s      cmp_ctrl,
	output cvc_pkg::cvc_ref_s      ref_ctrl,
	output logic                   first_output_pin,
	output logic                   first_output_pin_oe_n,
	output logic                   second_output_pin,
	output logic                   second_output_pin_oe_n,
	output logic                   ladder_pin_oe_n,
	output logic                   ladder_pin_drive,
	output logic                   reference_to_comparators,
	output logic                   ladder_powered,
	output logic                   comparator_irq_flag,
	output logic                   comparator_irq
);
	import cvc_pkg::*;

	logic [1:0] captured_out;
	logic       comparator_irq_enable;
	logic [1:0] seen_out;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction

	wire        access     = psel && penable;
	wire        wr         = access && pwrite;
	wire        hit_cmp    = hit(paddr, CVC_OFS_CMP);
	wire        hit_ref    = hit(paddr, CVC_OFS_REF);
	wire        hit_irq    = hit(paddr, CVC_OFS_IRQ);
	wire        hit_port   = hit(paddr, CVC_OFS_PORT);
	wire        mapped     = hit_cmp || hit_ref || hit_irq || hit_port;
	wire        mode_off   = (cmp_ctrl.comparator_mode_select == CVC_MODE_OFF);
	wire [1:0]  plain_out  = mode_off ? 2'h0 : {raw_second_compare, raw_first_compare};
	wire [1:0]  live_out   = plain_out ^ {cmp_ctrl.second_output_invert, cmp_ctrl.first_output_invert};
	wire        mismatch   = (live_out != captured_out);
	wire        cmp_touch  = access && hit_cmp;
	wire [7:0]  cmp_rd     = {live_out, cmp_ctrl.second_output_invert, cmp_ctrl.first_output_invert,
				  cmp_ctrl.input_switch, cmp_ctrl.comparator_mode_select};
	wire [7:0]  irq_rd     = {1'b0, comparator_irq_flag, comparator_irq_enable, 5'h00};
	// write picks invert bits by position
	wire cvc_cmp_s next_cmp = '{first_output_invert:    pwdata[CVC_CMP_INV1],
				   second_output_invert:   pwdata[CVC_CMP_INV2],
				   input_switch:           pwdata[CVC_CMP_SW],
				   comparator_mode_select: pwdata[2:0]};
	wire [7:0]  port_rd    = {port_pin_level & ~pin_is_analog, 1'b0};
	wire [7:0]  rd_mux     = hit_cmp ? cmp_rd : hit_ref ? ref_ctrl : hit_irq ? irq_rd :
				 hit_port ? port_rd : 8'h00;
	wire        flag_write = wr && hit_irq;
	wire        flag_set   = mismatch || (live_out != seen_out);
	// set wins over clear, no missed change
	wire        next_flag  = flag_set || (flag_write ? pwdata[CVC_IRQ_FLAG] : comparator_irq_flag);
	wire        next_ien   = flag_write ? pwdata[CVC_IRQ_FLAG - 1] : comparator_irq_enable;
	wire        next_p1oe  = !(output_routing_enable && !first_pin_direction);
	wire        next_p2oe  = !(output_routing_enable && !second_pin_direction);
	wire        next_lpoe  = !(ref_ctrl.ladder_pin_output_enable || !ladder_pin_direction);

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pready                  <= 1'b0;
			prdata                  <= 32'h0;
			pslverr                 <= 1'b0;
		end else begin
			pready                  <= psel && !penable;
			prdata                  <= {24'h0, rd_mux};
			pslverr                 <= psel && !penable && !mapped;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cmp_ctrl                <= cvc_cmp_s'({1'b0, CVC_CMP_RST});
			ref_ctrl                <= cvc_ref_s'(CVC_REF_RST);
			captured_out            <= 2'h0;
			seen_out                <= 2'h0;
			comparator_irq_flag     <= 1'b0;
			comparator_irq_enable   <= 1'b0;
		end else begin
			// status bits not writable, held otherwise
			if (wr && hit_cmp && pready)
				cmp_ctrl            <= next_cmp;
			if (wr && hit_ref && pready)
				ref_ctrl            <= cvc_ref_s'(pwdata[7:0]);
			if (cmp_touch && pready)
				captured_out        <= live_out;
			seen_out                <= live_out;
			if (pready || !flag_write)
				comparator_irq_flag <= next_flag;
			if (pready && flag_write)
				comparator_irq_enable <= next_ien;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			first_output_pin        <= 1'b0;
			second_output_pin       <= 1'b0;
			first_output_pin_oe_n   <= 1'b1;
			second_output_pin_oe_n  <= 1'b1;
			ladder_pin_oe_n         <= 1'b1;
			ladder_pin_drive        <= 1'b0;
			reference_to_comparators <= 1'b0;
			ladder_powered          <= 1'b0;
			comparator_irq          <= 1'b0;
		end else begin
			first_output_pin        <= live_out[0];
			second_output_pin       <= live_out[1];
			first_output_pin_oe_n   <= next_p1oe;
			second_output_pin_oe_n  <= next_p2oe;
			ladder_pin_oe_n         <= next_lpoe;
			// ladder pin drive uses power enable and pin output enable
			ladder_pin_drive        <= ref_ctrl.ladder_power_enable && ref_ctrl.ladder_pin_output_enable;
			reference_to_comparators <= (cmp_ctrl.comparator_mode_select == CVC_MODE_MUX) &&
						    cmp_ctrl.input_switch;
			ladder_powered          <= ref_ctrl.ladder_power_enable;
			comparator_irq          <= comparator_irq_flag && comparator_irq_enable &&
						   peripheral_irq_enable && global_irq_enable;
		end
	end
endmodule // cvc_top

// *** logic/cvc_pkg.sv ***
package cvc_pkg;
	// Register byte offsets on APB
	localparam logic [7:0] CVC_OFS_CMP   = 8'h00;
	localparam logic [7:0] CVC_OFS_REF   = 8'h04;
	localparam logic [7:0] CVC_OFS_IRQ   = 8'h08;
	localparam logic [7:0] CVC_OFS_PORT  = 8'h0c;
	// Field positions
	localparam int CVC_CMP_OUT2 = 7;
	localparam int CVC_CMP_OUT1 = 6;
	localparam int CVC_CMP_INV2 = 5;
	localparam int CVC_CMP_INV1 = 4;
	localparam int CVC_CMP_SW   = 3;
	localparam int CVC_REF_EN   = 7;
	localparam int CVC_REF_OE   = 6;
	localparam int CVC_REF_RNG  = 5;
	localparam int CVC_REF_SRC  = 4;
	localparam int CVC_IRQ_FLAG = 6;
	// Reset values and mode codes
	localparam logic [4:0] CVC_CMP_RST  = 5'h07;
	localparam logic [7:0] CVC_REF_RST  = 8'h00;
	localparam logic [2:0] CVC_MODE_OFF = 3'h7;
	localparam logic [2:0] CVC_MODE_MUX = 3'h6;

	typedef struct packed {
		logic       first_output_invert;
		logic       second_output_invert;
		logic       input_switch;
		logic [2:0] comparator_mode_select;
	} cvc_cmp_s;

	typedef struct packed {
		logic       ladder_power_enable;
		logic       ladder_pin_output_enable;
		logic       ladder_range_select;
		logic       ladder_source_select;
		logic [3:0] ladder_level_value;
	} cvc_ref_s;
endpackage

// *** testbench/cvc_checker.sv ***
`timescale 1ns/100ps
module cvc_checker import cvc_pkg::*; (
	input wire logic ref_clk, rst_n, psel, penable, pready, raw_first_compare, first_pin_direction,
	input wire logic peripheral_irq_enable, global_irq_enable, output_routing_enable, first_output_pin,
	input wire cvc_pkg::cvc_cmp_s cmp_ctrl,
	input wire cvc_pkg::cvc_ref_s ref_ctrl,
	input wire logic first_output_pin_oe_n, ladder_pin_oe_n, ladder_powered, reference_to_comparators,
	input wire logic comparator_irq_flag, comparator_irq,
	input wire logic raw_second_compare, second_pin_direction, second_output_pin, second_output_pin_oe_n,
	input wire logic ladder_pin_drive
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	wire logic on1 = cmp_ctrl.comparator_mode_select != CVC_MODE_OFF;
	// Output moved and then held while the bus is idle
	sequence first_moved;
		$changed(raw_first_compare) && on1 && !psel ##1 (!psel && on1 && $stable(raw_first_compare)) [*3];
	endsequence
	pready_wait_a: assert property (psel && !penable |=> pready) else $error("no answer");
	reset_state_a: assert property ($rose(rst_n) |-> cmp_ctrl == 6'h07 && ref_ctrl == CVC_REF_RST)
		else $error("reset state");
	flag_on_change_a: assert property (first_moved |-> ##[0:2] comparator_irq_flag) else $error("flag");
	irq_gated_a: assert property ((!peripheral_irq_enable || !global_irq_enable) [*3] |-> !comparator_irq)
		else $error("irq gate");
	pin_dir_gate_a: assert property (first_pin_direction [*2] |-> first_output_pin_oe_n) else $error("pin oe");
	pin_level_a: assert property ((output_routing_enable && $stable(raw_first_compare) && $stable(cmp_ctrl)) [*3]
		|-> first_output_pin == ((raw_first_compare && on1) ^ cmp_ctrl.first_output_invert)) else $error("pin level");
	ladder_pin_a: assert property (ref_ctrl.ladder_pin_output_enable [*2] |-> !ladder_pin_oe_n) else $error("lpin");
	ladder_power_a: assert property ($stable(ref_ctrl) [*2] |-> ladder_powered == ref_ctrl.ladder_power_enable)
		else $error("power");
	ref_mux_only_a: assert property ((cmp_ctrl.comparator_mode_select != CVC_MODE_MUX) [*2]
		|-> !reference_to_comparators) else $error("ref mux");
	second_dir_a: assert property (second_pin_direction [*2] |-> second_output_pin_oe_n) else $error("pin2 oe");
	second_level_a: assert property (($stable(raw_second_compare) && $stable(cmp_ctrl)) [*3]
		|-> second_output_pin == ((raw_second_compare && on1) ^ cmp_ctrl.second_output_invert))
		else $error("pin2 level");
	ladder_drive_a: assert property ($stable(ref_ctrl) [*2]
		|-> ladder_pin_drive == (ref_ctrl.ladder_power_enable && ref_ctrl.ladder_pin_output_enable))
		else $error("ladder drive");
endmodule // cvc_checker
bind cvc_top cvc_checker cvc_checker_inst (.ref_clk, .rst_n, .psel, .penable, .pready, .raw_first_compare,
	.first_pin_direction, .peripheral_irq_enable, .global_irq_enable, .output_routing_enable, .first_output_pin,
	.cmp_ctrl, .ref_ctrl, .first_output_pin_oe_n, .ladder_pin_oe_n, .ladder_powered, .reference_to_comparators,
	.comparator_irq_flag, .comparator_irq, .raw_second_compare, .second_pin_direction, .second_output_pin,
	.second_output_pin_oe_n, .ladder_pin_drive);

// *** testbench/testbench.sv ***
`timescale 1ns/100ps
module testbench;
	import cvc_pkg::*;
	logic ref_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, se, raw1 = 0, raw2 = 0, pen = 0, gen = 0;
	logic dir1 = 1, dir2 = 1, dirl = 1, route = 0;
	logic [7:0] paddr = '0;
	logic [31:0] pwdata = '0, rd, r;
	logic [7:1] lvl = '0, ana = '0;
	wire logic pready, pslverr, irq;
	wire logic [31:0] prdata;
	int mismatches = 0, num_checks = 0, cyc = 0;
	cvc_top cvc_top_inst (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
		.raw_first_compare(raw1), .raw_second_compare(raw2), .peripheral_irq_enable(pen), .global_irq_enable(gen),
		.first_pin_direction(dir1), .second_pin_direction(dir2), .ladder_pin_direction(dirl),
		.output_routing_enable(route), .port_pin_level(lvl), .pin_is_analog(ana), .cmp_ctrl(), .ref_ctrl(),
		.first_output_pin(), .first_output_pin_oe_n(), .second_output_pin(), .second_output_pin_oe_n(),
		.ladder_pin_oe_n(), .ladder_pin_drive(), .reference_to_comparators(), .ladder_powered(),
		.comparator_irq_flag(), .comparator_irq(irq));
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	// Setup, then access until pready, then release
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rd = prdata;
		se = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge ref_clk);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string n);
		apb(0, a, '0);
		chk(n, e, rd);
	endtask
	always #50 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			mismatches++;
			end_of_test();
		end
	end
	initial begin
		void'($urandom(69));
		repeat (12) @(posedge ref_clk);
		rst_n <= 1;
		@(posedge ref_clk);
		rdc(CVC_OFS_CMP, 32'h07, "cmp reset");
		rdc(CVC_OFS_REF, 32'h00, "ref reset");
		$display("reset test done");
		for (int i = 0; i < 8; i++) begin
			r = $urandom;
			{raw2, raw1, route, dir1, dir2, dirl} <= r[5:0];
			{ana, lvl} <= {r[22:16], r[14:8]};
			apb(1, CVC_OFS_CMP, {24'h0, r[31:28], 4'h6});
			rdc(CVC_OFS_CMP, {24'h0, r[5] ^ r[29], r[4] ^ r[28], r[29:28], 4'h6}, "status");
			apb(1, CVC_OFS_REF, {24'h0, r[15:8]});
			rdc(CVC_OFS_REF, {24'h0, r[15:8]}, "ref");
			rdc(CVC_OFS_PORT, {24'h0, r[14:8] & ~r[22:16], 1'b0}, "port");
			apb(0, 8'h10, '0);
			chk("slverr", 32'h1, {31'h0, se});
		end
		$display("register test done");
		apb(1, CVC_OFS_CMP, 32'h06);
		apb(1, CVC_OFS_IRQ, 32'h20);
		pen <= 1;
		gen <= 1;
		raw1 <= ~raw1;
		repeat (5) @(posedge ref_clk);
		chk("irq", 32'h1, {31'h0, irq});
		rdc(CVC_OFS_IRQ, 32'h60, "flag set");
		apb(0, CVC_OFS_CMP, '0);
		apb(1, CVC_OFS_IRQ, 32'h20);
		rdc(CVC_OFS_IRQ, 32'h20, "flag clear");
		apb(1, CVC_OFS_IRQ, 32'h60);
		rdc(CVC_OFS_IRQ, 32'h60, "flag soft");
		$display("flag test done");
		end_of_test();
	end
endmodule // testbench
